// *** hw/lsb_pkg.sv ***
// Shared constants and types for the logic, shift, bit and branch execution path
//
// Overview of operation
// - Literal AND: accumulator ANDed with 8-bit literal, result to accumulator, zero only.
// - File AND: accumulator ANDed with file register, destination bit picks target, zero only.
// - Signed shift: file bits 7..1 to result 6..0, bit 0 to carry.
// - Signed shift keeps bit 7; destination bit picks accumulator or file.
// - Bit clear: selected file bit forced to zero, others and flags kept.
// - Bit set: selected file bit forced to one, others and flags kept.
// - Literal jump: counter becomes incremented counter plus signed 9-bit offset, flags kept.
// - Literal jump takes two instruction cycles, limited signed range.
// - Accumulator jump: incremented counter plus unsigned accumulator, two cycles, flags kept.
// - Any counter-changing instruction runs its second cycle as a no-operation.
package lsb_pkg;

    // ========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int LIT_W = 9;
    localparam int PC_W = 15;

    // ========================================================
    // Reset values and fixed terms
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
    localparam int MSB_POS = 7;
    localparam int LIT_SIGN_POS = 8;

    // ========================================================
    // Operation codes
    typedef enum logic [2:0] {
        and_literal_into_accumulator,
        and_accumulator_with_file,
        signed_shift_right,
        clear_register_bit,
        set_register_bit,
        pc_relative_jump,
        jump_by_accumulator_offset,
        op_idle
    } lsb_op_t;

endpackage

// *** hw/lsb_res_if.sv ***
// Result bundle passed from the combinational unit to the sequencer
`timescale 1ns/1ps
interface lsb_res_if;
    import lsb_pkg::*;
    logic acc_we;
    logic [DATA_W-1:0] acc_val;
    logic file_we;
    logic [DATA_W-1:0] file_val;
    logic carry_we;
    logic carry_val;
    logic zero_we;
    logic zero_val;
    logic pc_load;
    logic [PC_W-1:0] pc_val;

    // Unit drives, sequencer consumes
    modport unit (
        output acc_we, acc_val, file_we, file_val, carry_we, carry_val,
        output zero_we, zero_val, pc_load, pc_val
    );
    modport core (
        input acc_we, acc_val, file_we, file_val, carry_we, carry_val,
        input zero_we, zero_val, pc_load, pc_val
    );
endinterface

// *** hw/lsb_alu.sv ***
// Combinational result unit for the logic, shift, bit and branch operations
`timescale 1ns/1ps
module lsb_alu (
    // Operation and operands
    input wire lsb_pkg::lsb_op_t op,
    input wire logic [lsb_pkg::LIT_W-1:0] lit,
    input wire logic dest_file,
    input wire logic [lsb_pkg::BIT_W-1:0] bit_sel,
    input wire logic [lsb_pkg::DATA_W-1:0] file_data,
    // Current architectural state
    input wire logic [lsb_pkg::DATA_W-1:0] acc,
    input wire logic [lsb_pkg::PC_W-1:0] pc,
    // Results
    lsb_res_if.unit res
);
    import lsb_pkg::*;

    logic [DATA_W-1:0] result;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] jump_off;

    // ========================================================
    // Result selection
    always_comb begin
        result = ZERO_BYTE;
        jump_off = PC_RST;
        // Counter plus one points past this instruction
        pc_inc = PC_W'(pc + PC_STEP);
        res.acc_we = 1'b0;
        res.file_we = 1'b0;
        res.carry_we = 1'b0;
        res.carry_val = 1'b0;
        res.zero_we = 1'b0;
        res.pc_load = 1'b0;
        unique case (op)
            and_literal_into_accumulator: begin
                result = acc & lit[DATA_W-1:0];
                res.acc_we = 1'b1;
                res.zero_we = 1'b1;
            end
            and_accumulator_with_file: begin
                result = acc & file_data;
                res.acc_we = !dest_file;
                res.file_we = dest_file;
                res.zero_we = 1'b1;
            end
            signed_shift_right: begin
                result[DATA_W-2:0] = file_data[DATA_W-1:1];
                res.carry_val = file_data[0];
                res.carry_we = 1'b1;
                res.zero_we = 1'b1;
                result[MSB_POS] = file_data[MSB_POS];
                res.acc_we = !dest_file;
                res.file_we = dest_file;
            end
            clear_register_bit: begin
                result = file_data;
                result[bit_sel] = 1'b0;
                res.file_we = 1'b1;
            end
            set_register_bit: begin
                result = file_data;
                result[bit_sel] = 1'b1;
                res.file_we = 1'b1;
            end
            pc_relative_jump: begin
                jump_off = {{(PC_W-LIT_W){lit[LIT_SIGN_POS]}}, lit};
                res.pc_load = 1'b1;
            end
            jump_by_accumulator_offset: begin
                jump_off = {{(PC_W-DATA_W){1'b0}}, acc};
                res.pc_load = 1'b1;
            end
            op_idle: begin
                result = ZERO_BYTE;
            end
        endcase
    end

    // ========================================================
    // Shared outputs
    // zero from result
    assign res.zero_val = (result == ZERO_BYTE);
    assign res.acc_val = result;
    assign res.file_val = result;
    assign res.pc_val = PC_W'(pc_inc + jump_off);

endmodule // lsb_alu

// *** hw/lsb_exec.sv ***
// Execution sequencer: accumulator, flags, program counter and file write-back
`timescale 1ns/1ps
module lsb_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Instruction request from the decoder
    input wire logic op_valid,
    input wire lsb_pkg::lsb_op_t op,
    input wire logic [lsb_pkg::LIT_W-1:0] lit,
    input wire logic [lsb_pkg::FADDR_W-1:0] file_addr,
    input wire logic dest_file,
    input wire logic [lsb_pkg::BIT_W-1:0] bit_sel,
    // File register read data, valid with the request
    input wire logic [lsb_pkg::DATA_W-1:0] file_rdata,
    // File register write-back
    output logic file_we,
    output logic [lsb_pkg::FADDR_W-1:0] file_waddr,
    output logic [lsb_pkg::DATA_W-1:0] file_wdata,
    // Architectural state
    output logic [lsb_pkg::DATA_W-1:0] acc,
    output logic carry,
    output logic zero,
    output logic [lsb_pkg::PC_W-1:0] pc,
    // Sequencing
    output logic op_ready,
    output logic op_done
);
    import lsb_pkg::*;

    // ========================================================
    // State
    typedef enum logic {
        lsb_run,
        lsb_flush
    } lsb_phase_t;

    typedef struct packed {
        lsb_phase_t phase;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic zero;
        logic [PC_W-1:0] pc;
        logic file_we;
        logic [FADDR_W-1:0] file_waddr;
        logic [DATA_W-1:0] file_wdata;
        logic done;
        logic ready;
    } lsb_state_t;

    lsb_state_t st_q;
    lsb_state_t st_d;
    logic take;

    lsb_res_if res_bus ();

    // ========================================================
    // Result unit
    lsb_alu u_alu (
        .op(op),
        .lit(lit),
        .dest_file(dest_file),
        .bit_sel(bit_sel),
        .file_data(file_rdata),
        .acc(st_q.acc),
        .pc(st_q.pc),
        .res(res_bus)
    );

    // Requests only land in the run phase
    assign take = op_valid && (st_q.phase == lsb_run);

    // ========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.file_we = 1'b0; // Write strobe lasts one cycle
        st_d.done = 1'b0;
        unique case (st_q.phase)
            lsb_run: begin
                if (take) begin
                    st_d.done = 1'b1;
                    if (res_bus.acc_we) begin
                        st_d.acc = res_bus.acc_val;
                    end
                    if (res_bus.carry_we) begin
                        st_d.carry = res_bus.carry_val;
                    end
                    if (res_bus.zero_we) begin
                        st_d.zero = res_bus.zero_val;
                    end
                    if (res_bus.file_we) begin
                        st_d.file_we = 1'b1;
                        st_d.file_waddr = file_addr;
                        st_d.file_wdata = res_bus.file_val;
                    end
                    if (res_bus.pc_load) begin
                        st_d.pc = res_bus.pc_val;
                        st_d.phase = lsb_flush;
                    end else begin
                        st_d.pc = PC_W'(st_q.pc + PC_STEP);
                    end
                end
            end
            lsb_flush: begin
                st_d.phase = lsb_run;
            end
        endcase
        // Ready kept as its own flop so the port has no gate behind it
        st_d.ready = (st_d.phase == lsb_run);
    end

    // ========================================================
    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q.phase <= lsb_run;
            st_q.acc <= ACC_RST;
            st_q.carry <= 1'b0;
            st_q.zero <= 1'b0;
            st_q.pc <= PC_RST;
            st_q.file_we <= 1'b0;
            st_q.file_waddr <= FADDR_RST;
            st_q.file_wdata <= ZERO_BYTE;
            st_q.done <= 1'b0;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // Outputs, all straight from the state register
    assign file_we = st_q.file_we;
    assign file_waddr = st_q.file_waddr;
    assign file_wdata = st_q.file_wdata;
    assign acc = st_q.acc;
    assign carry = st_q.carry;
    assign zero = st_q.zero;
    assign pc = st_q.pc;
    assign op_ready = st_q.ready; // Low during the no-op cycle
    assign op_done = st_q.done;

endmodule // lsb_exec

// *** tb/lsb_file_mem.sv ***
// File register memory model on the far side of the execution path
`timescale 1ns/1ps
module lsb_file_mem (
    // Clock
    input wire logic clock,
    // Read and write ports
    input wire logic [6:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [128];
    // Distinct fixed pattern so address slips show
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 8'h0D + 8'h91);
    // Combinational read; a pending write-back is forwarded since it lands one edge late
    assign rdata = (we && waddr == raddr) ? wdata : mem[raddr];
    // Write-back lands on the clock edge
    always @(posedge clock) if (we) mem[waddr] <= wdata;
endmodule // lsb_file_mem

// *** tb/lsb_exec_assertions.sv ***
// Port-level checker for the execution sequencer
`timescale 1ns/1ps
module lsb_exec_assertions (
    // Clock, reset and request
    input wire logic clock,
    input wire logic srst,
    input wire logic op_valid,
    input wire lsb_pkg::lsb_op_t op,
    input wire logic [8:0] lit,
    input wire logic [6:0] file_addr,
    input wire logic dest_file,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] file_rdata,
    // Outputs watched
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] acc,
    input wire logic carry,
    input wire logic zero,
    input wire logic [14:0] pc,
    input wire logic op_ready,
    input wire logic op_done
);
    import lsb_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Request taken and jump taken at this edge
    wire take = op_valid && op_ready;
    wire jmp = take && (op == pc_relative_jump || op == jump_by_accumulator_offset);
    a_done_pulse: assert property (take |=> op_done) else $error("done missing");
    a_no_stray: assert property (!take |=> !op_done) else $error("stray done");
    a_jump_flush: assert property (jmp |=> !op_ready ##1 (op_ready && !op_done))
        else $error("flush cycle wrong");
    a_lit_jump: assert property (take && op == pc_relative_jump |=>
        pc == $past(pc) + PC_STEP + {{6{$past(lit[8])}}, $past(lit)}) else $error("jump pc");
    a_acc_jump: assert property (take && op == jump_by_accumulator_offset |=>
        pc == $past(pc) + PC_STEP + {7'h00, $past(acc)}) else $error("acc jump pc");
    a_jump_flags: assert property (jmp |=> $stable(carry) && $stable(zero) && !file_we)
        else $error("jump touched state");
    a_and_lit: assert property (take && op == and_literal_into_accumulator |=>
        acc == ($past(acc) & $past(lit[7:0])) && zero == (acc == 8'h00) && $stable(carry))
        else $error("literal and");
    a_shift_res: assert property (take && op == signed_shift_right |=>
        carry == $past(file_rdata[0]) && (($past(dest_file) ? file_wdata : acc)
        == {$past(file_rdata[7]), $past(file_rdata[7:1])})) else $error("shift result");
    a_bit_flags: assert property (take && (op == clear_register_bit ||
        op == set_register_bit) |=> file_we && $stable(carry) && $stable(zero)
        && file_waddr == $past(file_addr)) else $error("bit op");
    a_bit_clear: assert property (take && op == clear_register_bit |=>
        file_wdata == ($past(file_rdata) & ~(8'h01 << $past(bit_sel))))
        else $error("bit clear data");
    a_bit_set: assert property (take && op == set_register_bit |=>
        file_wdata == ($past(file_rdata) | (8'h01 << $past(bit_sel))))
        else $error("bit set data");
    a_file_and: assert property (take && op == and_accumulator_with_file && dest_file |=>
        file_we && file_wdata == ($past(acc) & $past(file_rdata)) && $stable(acc))
        else $error("file and");
    // Main scenarios reached
    c_jump: cover property (jmp);
    c_shift_file: cover property (take && op == signed_shift_right && dest_file);
    c_bit_clear: cover property (take && op == clear_register_bit);
endmodule // lsb_exec_assertions

bind lsb_exec lsb_exec_assertions chk_u (.clock, .srst, .op_valid, .op, .lit, .file_addr,
    .dest_file, .bit_sel, .file_rdata, .file_we, .file_waddr, .file_wdata, .acc, .carry,
    .zero, .pc, .op_ready, .op_done);

// *** tb/lsb_exec_tb_top.sv ***
// Testbench for the execution sequencer with a file memory partner
`timescale 1ns/1ps
module lsb_exec_tb_top;
    import lsb_pkg::*;
    // ====================
    // Rows: inputs and the write strobe they should give
    typedef struct {lsb_op_t op; logic [8:0] lit; logic [6:0] fa; logic d; logic [2:0] b;
        logic we;} lsb_row_t;
    lsb_row_t rows [13] = '{
        '{signed_shift_right, 9'h000, 7'h00, 1'b0, 3'h0, 1'b0},
        '{and_literal_into_accumulator, 9'h0FF, 7'h00, 1'b0, 3'h0, 1'b0},
        '{and_accumulator_with_file, 9'h000, 7'h7F, 1'b1, 3'h0, 1'b1},
        '{clear_register_bit, 9'h000, 7'h00, 1'b0, 3'h7, 1'b1},
        '{set_register_bit, 9'h000, 7'h7F, 1'b0, 3'h0, 1'b1},
        '{signed_shift_right, 9'h000, 7'h7F, 1'b1, 3'h0, 1'b1},
        '{pc_relative_jump, 9'h100, 7'h00, 1'b0, 3'h0, 1'b0},
        '{jump_by_accumulator_offset, 9'h000, 7'h00, 1'b0, 3'h0, 1'b0},
        '{and_accumulator_with_file, 9'h000, 7'h05, 1'b0, 3'h0, 1'b0},
        '{and_literal_into_accumulator, 9'h000, 7'h00, 1'b0, 3'h0, 1'b0},
        '{pc_relative_jump, 9'h0FF, 7'h00, 1'b0, 3'h0, 1'b0},
        '{op_idle, 9'h000, 7'h00, 1'b0, 3'h0, 1'b0},
        '{set_register_bit, 9'h000, 7'h05, 1'b0, 3'h7, 1'b1}};
    logic clock = 1'b0, srst = 1'b1, op_valid = 1'b0, dest_file = 1'b0;
    lsb_op_t op = op_idle;
    logic [8:0] lit = 9'h000;
    logic [6:0] file_addr = 7'h00, file_waddr;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] file_rdata, file_wdata, acc, m_acc, f, r;
    logic [14:0] pc, m_pc;
    logic file_we, carry, zero, op_ready, op_done, m_c, m_z;
    int errors = 0, samples_checked = 0, cycles = 0;
    // Clock and design
    always #2.5 clock = ~clock;
    lsb_exec dut_u (.clock, .srst, .op_valid, .op, .lit, .file_addr, .dest_file, .bit_sel,
        .file_rdata, .file_we, .file_waddr, .file_wdata, .acc, .carry, .zero, .pc,
        .op_ready, .op_done);
    lsb_file_mem mem_u (.clock, .raddr(file_addr), .rdata(file_rdata), .we(file_we),
        .waddr(file_waddr), .wdata(file_wdata));
    // ====================
    task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset state, then restart the reference model
    task automatic reset_check;
        check("rst_state", {acc, carry, zero, file_we, op_done, op_ready}, {8'h00, 5'b00001});
        check("rst_pc", pc, 15'h0000);
        m_acc = 8'h00;
        m_c = 1'b0;
        m_z = 1'b0;
        m_pc = 15'h0000;
        $display("reset test done");
    endtask
    // One request; the reference works from the partner's read data
    task automatic do_row(lsb_row_t w);
        op_valid = 1'b1;
        op = w.op;
        lit = w.lit;
        file_addr = w.fa;
        dest_file = w.d;
        bit_sel = w.b;
        #1 f = file_rdata;
        case (w.op)
            and_literal_into_accumulator: r = m_acc & w.lit[7:0];
            and_accumulator_with_file: r = m_acc & f;
            signed_shift_right: r = {f[7], f[7:1]};
            clear_register_bit: r = f & ~(8'h01 << w.b);
            set_register_bit: r = f | (8'h01 << w.b);
            default: r = 8'h00;
        endcase
        if (w.op <= signed_shift_right) m_z = (r == 8'h00);
        if (w.op == signed_shift_right) m_c = f[0];
        if (w.op <= signed_shift_right && !w.d) m_acc = r;
        m_pc = m_pc + PC_STEP + (w.op == pc_relative_jump ? {{6{w.lit[8]}}, w.lit} :
            w.op == jump_by_accumulator_offset ? {7'h00, m_acc} : 15'h0000);
        @(posedge clock) #1;
        check("op_done", op_done, 1'b1);
        check("acc", acc, m_acc);
        check("carry", carry, m_c);
        check("zero", zero, m_z);
        check("pc", pc, m_pc);
        check("file_we", file_we, w.we);
        if (w.we) check("file_w", {file_waddr, file_wdata}, {w.fa, r});
        if (w.op == pc_relative_jump || w.op == jump_by_accumulator_offset) begin
            check("op_ready", op_ready, 1'b0);
            // A real literal AND offered in the no-op cycle must be ignored
            op = and_literal_into_accumulator;
            lit = 9'h000;
            @(posedge clock) #1;
            check("refused", {op_done, pc}, {1'b0, m_pc});
            check("refused_acc", {acc, zero}, {m_acc, m_z});
            check("op_ready_back", op_ready, 1'b1);
        end
    endtask
    // Main sequence: rows back to back, then a reset in mid-run
    initial begin
        repeat (16) @(posedge clock);
        #1 srst = 1'b0;
        @(posedge clock) #1;
        reset_check();
        foreach (rows[i]) begin
            do_row(rows[i]);
            $display("row %0d done", i);
        end
        op_valid = 1'b0;
        srst = 1'b1;
        @(posedge clock) #1;
        srst = 1'b0;
        reset_check();
        @(posedge clock) #1;
        do_row(rows[0]);
        tally_and_finish();
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 500) begin
            errors++;
            tally_and_finish();
        end
    end
endmodule // lsb_exec_tb_top
